// ==== design/srb_top.sv ====
// sram region decoder with bit-band alias translation
// assumes an ahb-lite slave port, one-cycle synchronous sram behind it
`timescale 1ns/1ns
`default_nettype none
module srb_top (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [3:0]  hprot,
	input  wire logic [31:0] hwdata,
	input  wire logic        hmaster_core,
	output logic [31:0]      hrdata,
	output logic             hready,
	output logic             hresp,
	output logic             mem_req,
	output logic             mem_we,
	output logic [2:0]       mem_bank,
	output logic [15:0]      mem_addr,
	output logic [3:0]       mem_be,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		srb_pkg::srb_state_e state;
		logic        hready;
		logic        hresp;
		logic [31:0] hrdata;
		logic        mem_req;
		logic        mem_we;
		logic [2:0]  mem_bank;
		logic [15:0] mem_addr;
		logic [3:0]  mem_be;
		logic [31:0] mem_wdata;
		logic        alias_acc;
		logic [1:0]  lane;
		logic [2:0]  bitpos;
		logic        wbit;
	} srb_state_s;

	srb_state_s st_r;
	srb_state_s st_nxt;

	// byte enables from transfer size and low address bits
	function automatic logic [3:0] be_of(input logic [2:0] sz, input logic [1:0] a);
		if (sz[1:0] == srb_pkg::HSIZE_BYTE)
			return 4'(4'h1 << a);
		else if (sz[1:0] == srb_pkg::HSIZE_HALF)
			return a[1] ? 4'hc : 4'h3;
		else
			return 4'hf;
	endfunction : be_of

	// ****************************************
	// address classification
	// ****************************************
	logic        take;
	logic        in_area;
	logic        is_alias;
	logic [31:0] aoff;
	logic [22:0] bidx;
	logic [31:0] bb_addr;
	logic [31:0] eff_addr;
	logic        dec_hit;
	logic [2:0]  dec_bank;
	logic [15:0] dec_widx;
	logic        bad;
	logic [4:0]  sel_idx;
	logic        sel_bit;

	// hprot is not consulted: fetches and data use one uncached path [RL9]
	assign take     = ce && hsel && htrans[1] && st_r.state == srb_pkg::ST_IDLE;
	assign in_area  = haddr >= srb_pkg::SRAM_AREA_BASE && haddr <= srb_pkg::SRAM_AREA_LAST; // [RL1]
	assign is_alias = haddr >= srb_pkg::ALIAS_BASE && haddr <= srb_pkg::ALIAS_LAST; // [RL4]
	// alias offset / 4 is the bit index, index / 8 the byte [RL15] [RL5]
	assign aoff     = haddr - srb_pkg::ALIAS_BASE;
	assign bidx     = aoff[24:2];
	assign bb_addr  = srb_pkg::SRAM_AREA_BASE + {12'h000, bidx[22:3]}; // [RL3]
	assign eff_addr = is_alias ? bb_addr : haddr;
	// alias words from other controllers look unimplemented [RL8]
	assign bad      = !in_area || !dec_hit || (is_alias && !hmaster_core) ||
	                  (is_alias && bb_addr > srb_pkg::BB_PRIMARY_LAST); // [RL14]
	assign sel_idx  = {st_r.lane, st_r.bitpos};
	assign sel_bit  = mem_rdata[sel_idx];

	srb_bank_decode u_dec (
		.addr (eff_addr),
		.hit  (dec_hit),
		.bank (dec_bank),
		.widx (dec_widx)
	);

	// ****************************************
	// next state
	// ****************************************
	// write flow waits one cycle for the ahb data phase before touching sram
	always_comb begin
		logic [31:0] wd;
		wd = mem_rdata;
		st_nxt = st_r;
		st_nxt.mem_req = 1'b0;
		st_nxt.mem_we  = 1'b0;
		case (st_r.state)
			srb_pkg::ST_IDLE: begin
				st_nxt.hresp = 1'b0;
				if (take) begin
					st_nxt.hready    = 1'b0;
					st_nxt.alias_acc = is_alias;
					st_nxt.lane      = is_alias ? bb_addr[1:0] : haddr[1:0];
					st_nxt.bitpos    = bidx[2:0];
					st_nxt.mem_bank  = dec_bank;
					st_nxt.mem_addr  = dec_widx;
					st_nxt.mem_be    = be_of(hsize, haddr[1:0]); // [RL13]
					if (bad) begin
						st_nxt.state = srb_pkg::ST_ERR1;
						st_nxt.hresp = 1'b1; // [RL8] [RL14]
					end else if (hwrite && is_alias) begin
						st_nxt.state = srb_pkg::ST_AWD;
					end else if (hwrite) begin
						st_nxt.state = srb_pkg::ST_WR; // [RL10]
					end else begin
						st_nxt.state   = srb_pkg::ST_RD1; // [RL7]
						st_nxt.mem_req = 1'b1;
					end
				end
			end
			srb_pkg::ST_RD1: begin
				st_nxt.state = srb_pkg::ST_RD2;
			end
			srb_pkg::ST_RD2: begin
				// alias read returns the single selected bit in bit 0
				st_nxt.hrdata = st_r.alias_acc ? {31'h0, sel_bit} : mem_rdata; // [RL6]
				st_nxt.hready = 1'b1;
				st_nxt.state  = srb_pkg::ST_IDLE;
			end
			srb_pkg::ST_WR: begin
				st_nxt.mem_req   = 1'b1;
				st_nxt.mem_we    = 1'b1;
				st_nxt.mem_wdata = hwdata; // [RL13]
				st_nxt.hready    = 1'b1;
				st_nxt.state     = srb_pkg::ST_IDLE;
			end
			srb_pkg::ST_AWD: begin
				st_nxt.wbit    = hwdata[0];
				st_nxt.mem_req = 1'b1; // [RL7]
				st_nxt.state   = srb_pkg::ST_RMW1;
			end
			srb_pkg::ST_RMW1: begin
				st_nxt.state = srb_pkg::ST_RMW2;
			end
			srb_pkg::ST_RMW2: begin
				// only the target bit changes; the byte lane limits the write
				wd[sel_idx]      = st_r.wbit; // [RL6]
				st_nxt.mem_wdata = wd;
				st_nxt.mem_be    = 4'(4'h1 << st_r.lane);
				st_nxt.mem_req   = 1'b1;
				st_nxt.mem_we    = 1'b1; // [RL7]
				st_nxt.hready    = 1'b1;
				st_nxt.state     = srb_pkg::ST_IDLE;
			end
			srb_pkg::ST_ERR1: begin
				st_nxt.hready = 1'b1;
				st_nxt.state  = srb_pkg::ST_ERR2;
			end
			srb_pkg::ST_ERR2: begin
				st_nxt.hresp = 1'b0;
				st_nxt.state = srb_pkg::ST_IDLE;
			end
			default: begin
				st_nxt.state  = srb_pkg::ST_IDLE;
				st_nxt.hready = srb_pkg::HREADY_RST;
				st_nxt.hresp  = 1'b0;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r        <= '0;
			st_r.state  <= srb_pkg::ST_IDLE;
			st_r.hready <= srb_pkg::HREADY_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// outputs come straight from the state flops
	assign hrdata    = st_r.hrdata;
	assign hready    = st_r.hready;
	assign hresp     = st_r.hresp;
	assign mem_req   = st_r.mem_req;
	assign mem_we    = st_r.mem_we;
	assign mem_bank  = st_r.mem_bank;
	assign mem_addr  = st_r.mem_addr;
	assign mem_be    = st_r.mem_be;
	assign mem_wdata = st_r.mem_wdata;

	// ****************************************
	// assertions
	// ****************************************
	logic [31:0] rmw_old;
	assign rmw_old = mem_rdata;

	a_alias_dma_err: assert property (@(posedge clock) disable iff (!rstn) // [RL8]
		take && is_alias && !hmaster_core |=> hresp && !hready && !mem_req)
		else $error("non-core alias access not errored");
	a_hole_err: assert property (@(posedge clock) disable iff (!rstn) // [RL14]
		take && !is_alias && in_area && !dec_hit |=> hresp && !hready)
		else $error("unimplemented sram hole not errored");
	a_alias_range: assert property (@(posedge clock) disable iff (!rstn) // [RL3]
		take && is_alias && hmaster_core && !dec_hit |=> hresp && !hready && !mem_req)
		else $error("alias to unimplemented byte not errored");
	a_alias_rd_bit: assert property (@(posedge clock) disable iff (!rstn) // [RL6]
		ce && st_r.state == srb_pkg::ST_RD2 && st_r.alias_acc
		|=> hready && hrdata == {31'h0, $past(sel_bit)})
		else $error("alias read returned wrong bit");
	a_rmw_write: assert property (@(posedge clock) disable iff (!rstn) // [RL7]
		ce && st_r.state == srb_pkg::ST_RMW2
		|=> mem_req && mem_we && $onehot(mem_be) && mem_wdata[$past(sel_idx)] == $past(st_r.wbit))
		else $error("alias write did not modify the bit");
	a_rmw_keep: assert property (@(posedge clock) disable iff (!rstn) // [RL6]
		ce && st_r.state == srb_pkg::ST_RMW2 && !st_r.wbit
		|=> (mem_wdata == ($past(rmw_old) & ~(32'h1 << $past(sel_idx)))))
		else $error("clear disturbed other bits");
	a_dma_primary: assert property (@(posedge clock) disable iff (!rstn) // [RL10]
		take && !hmaster_core && !is_alias && in_area && dec_hit && !hwrite
		|=> mem_req && !mem_we && !hresp)
		else $error("dma primary read not served");
	a_bank_six: assert property (@(posedge clock) disable iff (!rstn) // [RL14]
		take && !is_alias && haddr >= srb_pkg::BANK_BASE[6] && haddr < srb_pkg::BANK_BASE[7]
		|=> mem_bank == 3'h6)
		else $error("bank six misdecoded");
	a_core_alias_rd: assert property (@(posedge clock) disable iff (!rstn) // [RL5]
		take && is_alias && hmaster_core && !bad && !hwrite |=> mem_req && !mem_we && !hresp)
		else $error("core alias read not translated");

	c_alias_write: cover property (@(posedge clock) st_r.state == srb_pkg::ST_RMW2 && ce);
	c_alias_read: cover property (@(posedge clock) st_r.state == srb_pkg::ST_RD2 && st_r.alias_acc);
	c_error: cover property (@(posedge clock) st_r.state == srb_pkg::ST_ERR2);
	c_byte_write: cover property (@(posedge clock) mem_we && mem_be == 4'h2);

endmodule : srb_top
`default_nettype wire

// ==== design/srb_pkg.sv ====
// constants shared by the sram region and bit-band decoder
// assumes a single ahb-lite style port driven by the system bus matrix
// How it works
// (RL1) byte addresses 0x2000_0000..0x3fff_ffff are claimed as the sram area
// (RL2) the populated sram totals 160kb across eight banks
// (RL3) all sram lies in the bit-band primary window 0x2000_0000..0x200f_ffff
// (RL4) the alias area starts at 0x2200_0000 and spans 32mb
// (RL5) each aligned alias word maps to exactly one sram bit
// (RL6) alias read returns the bit; write 1 sets, write 0 clears it
// (RL7) alias read becomes a primary read; alias write a byte read-modify-write
// (RL8) alias access from a non-core controller ends in an ahb error
// (RL9) sram instruction fetches go straight to memory, never cached
// (RL10) dma and other controllers get normal access to the primary area
// (RL11) banks 0..3: 16kb, 16kb, 32kb, 64kb from 0x2000_0000 upward
// (RL12) banks 4..7: 4kb, 4kb, 8kb, 16kb from 0x2002_0000 upward
// (RL13) byte addressed; word, halfword and byte accesses all accepted
// (RL14) bank six starts at 0x2002_2000; holes in the area answer error
// (RL15) bit index is alias offset / 4; byte is base + index / 8
package srb_pkg;

	// ****************************************
	// address map
	// ****************************************
	localparam logic [31:0] SRAM_AREA_BASE  = 32'h2000_0000;
	localparam logic [31:0] SRAM_AREA_LAST  = 32'h3fff_ffff;
	localparam logic [31:0] BB_PRIMARY_LAST = 32'h200f_ffff;
	localparam logic [31:0] ALIAS_BASE      = 32'h2200_0000;
	localparam logic [31:0] ALIAS_LAST      = 32'h23ff_ffff;
	localparam logic [31:0] SRAM_TOTAL      = 32'h0002_8000;
	localparam int          NUM_BANKS       = 8;

	// bank bases and sizes, bank six kept contiguous
	localparam logic [31:0] BANK_BASE [NUM_BANKS] = '{
		32'h2000_0000, 32'h2000_4000, 32'h2000_8000, 32'h2001_0000,
		32'h2002_0000, 32'h2002_1000, 32'h2002_2000, 32'h2002_4000};
	localparam logic [31:0] BANK_SIZE [NUM_BANKS] = '{
		32'h0000_4000, 32'h0000_4000, 32'h0000_8000, 32'h0001_0000,
		32'h0000_1000, 32'h0000_1000, 32'h0000_2000, 32'h0000_4000};

	// ****************************************
	// bus encodings and reset values
	// ****************************************
	localparam logic [1:0] HSIZE_BYTE = 2'h0;
	localparam logic [1:0] HSIZE_HALF = 2'h1;
	localparam logic       HREADY_RST = 1'h1;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_RD1  = 4'h1,
		ST_RD2  = 4'h3,
		ST_WR   = 4'h4,
		ST_AWD  = 4'h2,
		ST_RMW1 = 4'h6,
		ST_RMW2 = 4'h7,
		ST_ERR1 = 4'h8,
		ST_ERR2 = 4'h9
	} srb_state_e;

endpackage : srb_pkg

// ==== design/srb_bank_decode.sv ====
// bank decoder: maps a primary-area byte address to bank and word index
// assumes the address is already known to be in the sram area
`timescale 1ns/1ns
`default_nettype none
module srb_bank_decode (
	input  wire logic [31:0] addr,
	output logic             hit,
	output logic [2:0]       bank,
	output logic [15:0]      widx
);
	logic [31:0] off;

	// first matching bank wins; banks never overlap so order is moot
	always_comb begin
		hit  = 1'b0;
		bank = 3'h0;
		off  = addr - srb_pkg::SRAM_AREA_BASE;
		widx = off[17:2]; // [RL2] 160kb of words fits the 16-bit index
		for (int i = 0; i < srb_pkg::NUM_BANKS; i++) begin
			if (!hit && addr >= srb_pkg::BANK_BASE[i] &&
			    addr < srb_pkg::BANK_BASE[i] + srb_pkg::BANK_SIZE[i]) begin // [RL11] [RL12]
				hit  = 1'b1; // [RL14]
				bank = 3'(i);
			end
		end
	end
endmodule : srb_bank_decode
`default_nettype wire

// ==== tb/srb_sram_model.sv ====
// sram partner model: word array with byte enables and one-cycle read latency
// assumes mem_addr is a word index from the bottom of sram
`timescale 1ns/1ns
`default_nettype none
module srb_sram_model (
	input  wire logic        clock,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [3:0]  mem_be,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata
);
	logic [31:0] ram [0:40959];

	// read data is good for one cycle only; it flips after that so stale data never matches
	always @(posedge clock) begin
		if (mem_req === 1'b1 && mem_we === 1'b0)
			mem_rdata <= ram[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_req === 1'b1 && mem_we === 1'b1)
			for (int i = 0; i < 4; i++)
				if (mem_be[i])
					ram[mem_addr][i*8+:8] <= mem_wdata[i*8+:8];
	end

	// cleared storage so that alias reads see known bits
	initial begin
		mem_rdata = 32'h0;
		foreach (ram[i])
			ram[i] = 32'h0;
	end
endmodule : srb_sram_model
`default_nettype wire

// ==== tb/srb_top_tb_top.sv ====
// bench for the sram region decoder: core and dma masters, sram model behind
// assumes one transfer at a time and a clock enable held high outside the freeze test
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module srb_top_tb_top;
	logic        clock, rstn, ce, hsel, hwrite, hmaster_core, hready, hresp, mem_req, mem_we;
	logic [1:0]  htrans;
	logic [2:0]  hsize, mem_bank, seen_bank;
	logic [3:0]  hprot, mem_be;
	logic [15:0] mem_addr;
	logic [31:0] haddr, hwdata, hrdata, mem_wdata, mem_rdata, last_rd;
	int          error_cnt, n_tests;
	// bank map as the memory layout gives it, bank six kept contiguous
	localparam logic [31:0] BASE [8] = '{32'h2000_0000, 32'h2000_4000, 32'h2000_8000,
		32'h2001_0000, 32'h2002_0000, 32'h2002_1000, 32'h2002_2000, 32'h2002_4000};
	localparam logic [31:0] SIZE [8] = '{32'h4000, 32'h4000, 32'h8000, 32'h1_0000,
		32'h1000, 32'h1000, 32'h2000, 32'h4000};

	srb_top srb_top_inst (.clock, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hprot, .hwdata, .hmaster_core, .hrdata, .hready, .hresp, .mem_req,
		.mem_we, .mem_bank, .mem_addr, .mem_be, .mem_wdata, .mem_rdata);
	srb_sram_model srb_sram_model_inst (.clock, .mem_req, .mem_we, .mem_addr, .mem_be,
		.mem_wdata, .mem_rdata);

	// clock and bank capture at each sram access
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// follows the bank while a request stands, so a write is seen before its data edge
	always @(mem_req or mem_bank)
		if (mem_req === 1'b1)
			seen_bank = mem_bank;

	function automatic logic [31:0] alias_of(input logic [31:0] a, input logic [2:0] b);
		return 32'h2200_0000 + ((((a - 32'h2000_0000) << 3) + {29'h0, b}) << 2);
	endfunction : alias_of

	// one ahb transfer; checks response, busy length, and the quiet cycle after an error
	task automatic op(input logic [31:0] a, input logic w, input logic [2:0] sz,
		input logic [31:0] wd, input logic core, input logic ers, input int elat);
		int lat;
		@(posedge clock);
		#1;
		hsel = 1'b1;
		htrans = 2'h2;
		haddr = a;
		hwrite = w;
		hsize = sz;
		hmaster_core = core;
		@(posedge clock);
		#1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwdata = wd;
		lat = 0;
		while (hready !== 1'b1 && lat < 20) begin
			@(posedge clock);
			#1;
			lat++;
		end
		last_rd = hrdata;
		`CHK(hresp, ers)
		`CHK(lat, elat)
		if (ers) begin
			@(posedge clock);
			#1;
			`CHK(hresp, 1'b0)
		end
	endtask : op

	task automatic t_banks;
		for (int i = 0; i < 8; i++) begin
			op(BASE[i], 1'b1, 3'h2, 32'hc0de_0000 | i, 1'b1, 1'b0, 1);
			`CHK(seen_bank, 3'(i))
			op(BASE[i] + SIZE[i] - 4, 1'b1, 3'h2, 32'h5a00_0000 | i, 1'b0, 1'b0, 1);
			`CHK(seen_bank, 3'(i))
			op(BASE[i], 1'b0, 3'h2, 32'h0, 1'b0, 1'b0, 2);
			`CHK(last_rd, 32'hc0de_0000 | i)
		end
		$display("test banks done");
	endtask : t_banks

	task automatic t_sizes;
		op(32'h2000_0100, 1'b1, 3'h2, 32'h0, 1'b1, 1'b0, 1);
		op(32'h2000_0101, 1'b1, 3'h0, 32'h0000_ab00, 1'b1, 1'b0, 1);
		op(32'h2000_0102, 1'b1, 3'h1, 32'h1234_0000, 1'b1, 1'b0, 1);
		hprot = 4'h0;
		op(32'h2000_0100, 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		hprot = 4'h3;
		`CHK(last_rd, 32'h1234_ab00)
		$display("test sizes done");
	endtask : t_sizes

	task automatic t_alias;
		op(32'h2000_0200, 1'b1, 3'h2, 32'hffff_0f0f, 1'b1, 1'b0, 1);
		op(alias_of(32'h2000_0201, 3'h4), 1'b1, 3'h2, 32'h1, 1'b1, 1'b0, 3);
		op(32'h2000_0200, 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		`CHK(last_rd, 32'hffff_1f0f)
		op(alias_of(32'h2000_0201, 3'h4), 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		`CHK(last_rd, 32'h1)
		op(alias_of(32'h2000_0200, 3'h0), 1'b1, 3'h2, 32'hffff_fffe, 1'b1, 1'b0, 3);
		op(32'h2000_0200, 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		`CHK(last_rd, 32'hffff_1f0e)
		op(alias_of(32'h2002_7fff, 3'h7), 1'b1, 3'h2, 32'h1, 1'b1, 1'b0, 3);
		op(32'h2002_7ffc, 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		`CHK(last_rd, 32'hda00_0007)
		op(alias_of(32'h2000_0201, 3'h4), 1'b0, 3'h2, 32'h0, 1'b0, 1'b1, 1);
		op(alias_of(32'h2000_0201, 3'h4), 1'b1, 3'h2, 32'h0, 1'b0, 1'b1, 1);
		$display("test alias done");
	endtask : t_alias

	task automatic t_errors;
		logic [31:0] bad [6] = '{32'h1fff_fffc, 32'h4000_0000, 32'h2002_8000,
			32'h200f_fffc, 32'h3fff_fffc, 32'h2250_0000};
		foreach (bad[i])
			op(bad[i], 1'b0, 3'h2, 32'h0, 1'b1, 1'b1, 1);
		$display("test errors done");
	endtask : t_errors

	// reset in mid-run: outputs go to their idle values, stored words survive
	task automatic t_reset;
		@(posedge clock);
		#1;
		rstn = 1'b0;
		@(posedge clock);
		#1;
		`CHK(hready, 1'b1)
		`CHK({hresp, mem_req, mem_we, mem_be}, 7'h0)
		`CHK(hrdata, 32'h0)
		rstn = 1'b1;
		op(32'h2000_0200, 1'b0, 3'h2, 32'h0, 1'b1, 1'b0, 2);
		`CHK(last_rd, 32'hffff_1f0e)
		$display("test reset done");
	endtask : t_reset

	// ce low mid-read freezes the block; the read resumes where it stopped
	task automatic t_freeze;
		int lat;
		op(32'h2000_0300, 1'b1, 3'h2, 32'h0bad_f00d, 1'b0, 1'b0, 1);
		@(posedge clock);
		#1;
		{hsel, htrans, haddr, hwrite} = {1'b1, 2'h2, 32'h2000_0300, 1'b0};
		@(posedge clock);
		#1;
		{hsel, htrans, ce} = 4'h0;
		repeat (3) @(posedge clock);
		#1;
		`CHK(hready, 1'b0)
		ce = 1'b1;
		lat = 0;
		while (hready !== 1'b1 && lat < 20) begin
			@(posedge clock);
			#1;
			lat++;
		end
		`CHK(lat, 2)
		`CHK(hrdata, 32'h0bad_f00d)
		$display("test freeze done");
	endtask : t_freeze

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	// watchdog well past the fewer than two hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end

	initial begin
		rstn = 1'b0;
		{hsel, hwrite, hmaster_core, htrans, hsize, haddr, hwdata} = '0;
		hprot = 4'h3;
		ce = 1'b1;
		repeat (12) @(posedge clock);
		#1;
		rstn = 1'b1;
		t_banks();
		t_sizes();
		t_alias();
		t_reset();
		t_freeze();
		t_errors();
		close_out();
	end
endmodule : srb_top_tb_top
`default_nettype wire
